// ==== core/ssp_core.sv ====
`timescale 1ns/1ps
module ssp_core #(
  parameter int unsigned NUM_PG = ssp_pkg::PG_NUM,
  parameter int unsigned NUM_INT = ssp_pkg::SEQ_MAX
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic trigger_i,
  input wire logic sequence_hw_trigger_i,
  input wire logic [NUM_PG-1:0] pg_hw_trigger_i,
  output logic [NUM_PG-1:0] pulse_o,
  output logic integration_start_o,
  output logic strobe_o,
  output logic exposure_o,
  output logic seq_active_o,
  output logic seq_pulse_o,
  output logic [ssp_pkg::PWM_NUM-1:0] pwm_o
);
  import ssp_pkg::*;

  localparam logic [31:0] US_CYC = 32'(US_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(US_CYCLES - 1);
  localparam logic [US_W-1:0] STB_MIN = US_W'(STB_MIN_US);
  localparam logic [US_W-1:0] STB_MAX = US_W'(STB_MAX_US);
  localparam logic [DUTY_W-1:0] DUTY_FULL = DUTY_W'(PCT_FULL);
  localparam logic [39:0] PCT40 = 40'(PCT_FULL);

  // Register file
  logic [2:0] ctrl_reg;
  logic [US_W-1:0] exp_delay_reg;
  logic [US_W-1:0] stb_delay_reg;
  logic [US_W-1:0] stb_dur_reg;
  logic [4:0] seq_count_reg;
  logic [2:0] pg_cfg_reg [NUM_PG];
  logic [31:0] pg_pre_reg [NUM_PG];
  logic [31:0] pg_post_reg [NUM_PG];
  logic [LOOP_W-1:0] pg_loops_reg [NUM_PG];
  logic [31:0] seq_mem_reg [NUM_INT][SEQ_FIELDS];
  logic tim_go_reg, seq_go_reg;
  logic [NUM_PG-1:0] pg_go_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic [NUM_PG-1:0] pg_busy;

  // Address decode pieces
  logic is_pg, is_seq;
  logic [1:0] pg_sel, pg_fld;
  logic [3:0] sq_sel, sq_fld;
  assign is_pg = (addr_i[11:6] == ADDR_PG_PAGE);
  assign is_seq = (addr_i[11:10] == ADDR_SEQ_PAGE);
  assign pg_sel = addr_i[5:4];
  assign pg_fld = addr_i[3:2];
  assign sq_sel = addr_i[9:6];
  assign sq_fld = addr_i[5:2];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_reg <= '0;
      exp_delay_reg <= '0;
      stb_delay_reg <= '0;
      stb_dur_reg <= STB_MIN;
      seq_count_reg <= SEQ_COUNT_RST;
      for (int i = 0; i < NUM_PG; i++) begin
        pg_cfg_reg[i] <= '0;
        pg_pre_reg[i] <= '0;
        pg_post_reg[i] <= '0;
        pg_loops_reg[i] <= '0;
      end
    end else if (wr_i) begin
      if (addr_i == ADDR_CTRL) begin
        ctrl_reg <= wdata_i[2:0];
      end else if (addr_i == ADDR_EXP_DELAY) begin
        exp_delay_reg <= wdata_i[US_W-1:0];
      end else if (addr_i == ADDR_STB_DELAY) begin
        stb_delay_reg <= wdata_i[US_W-1:0];
      end else if (addr_i == ADDR_STB_DUR) begin
        stb_dur_reg <= wdata_i[US_W-1:0];
      end else if (addr_i == ADDR_SEQ_COUNT) begin
        seq_count_reg <= wdata_i[4:0];
      end else if (is_pg && 32'(pg_sel) < NUM_PG) begin
        if (pg_fld == PG_REG_CFG) begin
          pg_cfg_reg[pg_sel] <= wdata_i[2:0];
        end else if (pg_fld == PG_REG_PRE) begin
          pg_pre_reg[pg_sel] <= wdata_i;
        end else if (pg_fld == PG_REG_POST) begin
          pg_post_reg[pg_sel] <= wdata_i;
        end else begin
          pg_loops_reg[pg_sel] <= wdata_i[LOOP_W-1:0];
        end
      end
    end
  end

  // Interval storage, one word per field per interval
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_INT; i++) begin
        for (int f = 0; f < SEQ_FIELDS; f++) begin
          seq_mem_reg[i][f] <= '0;
        end
      end
    end else if (wr_i && is_seq && 32'(sq_fld) < SEQ_FIELDS) begin
      seq_mem_reg[sq_sel][sq_fld] <= wdata_i;
    end
  end

  // Software triggers are write pulses, never stored
  always_ff @(posedge clk_i) begin
    if (reset_i || !(wr_i && addr_i == ADDR_CTRL)) begin
      tim_go_reg <= 1'b0;
      seq_go_reg <= 1'b0;
      pg_go_reg <= '0;
    end else begin
      tim_go_reg <= wdata_i[CTRL_TIM_GO];
      seq_go_reg <= wdata_i[CTRL_SEQ_GO];
      pg_go_reg <= wdata_i[CTRL_PG_GO +: NUM_PG];
    end
  end

  // Pulse generators
  genvar g;
  generate
    for (g = 0; g < NUM_PG; g++) begin : gen_pg
      ssp_pulse_gen #(
        .DUR_W(32),
        .CNT_W(LOOP_W)
      ) u_pg (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .hw_trig_i(pg_hw_trigger_i[g]),
        .sw_trig_i(pg_go_reg[g]),
        .use_sw_i(pg_cfg_reg[g][PG_CFG_SW]),
        .level_mode_i(pg_cfg_reg[g][PG_CFG_LEVEL]),
        .start_high_i(pg_cfg_reg[g][PG_CFG_HIGH]),
        .pre_i(pg_pre_reg[g]),
        .post_i(pg_post_reg[g]),
        .loops_i(pg_loops_reg[g]),
        .pulse_o(pulse_o[g]),
        .busy_o(pg_busy[g])
      );
    end
  endgenerate

  // Trigger-relative exposure and strobe timing
  logic trig_prev_reg, tim_trig;
  logic exp_run_reg;
  logic [31:0] exp_cnt_reg, exp_cyc, stb_dly_cyc, stb_dur_cyc;
  logic [US_W-1:0] stb_dur_eff;
  ssp_stb_state_t stb_state_reg;
  logic [31:0] stb_cnt_reg;

  assign tim_trig = ctrl_reg[CTRL_TIM_SW] ? tim_go_reg : (trigger_i & ~trig_prev_reg);
  assign exp_cyc = 32'(exp_delay_reg) * US_CYC;
  assign stb_dly_cyc = 32'(stb_delay_reg) * US_CYC;
  // Out-of-range widths are clamped rather than refused
  assign stb_dur_eff = (stb_dur_reg < STB_MIN) ? STB_MIN :
    ((stb_dur_reg > STB_MAX) ? STB_MAX : stb_dur_reg);
  assign stb_dur_cyc = 32'(stb_dur_eff) * US_CYC;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trigger_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      exp_run_reg <= 1'b0;
      exp_cnt_reg <= '0;
      integration_start_o <= 1'b0;
    end else begin
      integration_start_o <= 1'b0;
      if (tim_trig && !exp_run_reg) begin
        exp_run_reg <= 1'b1;
        exp_cnt_reg <= '0;
      end else if (exp_run_reg) begin
        if (exp_cnt_reg >= exp_cyc) begin
          exp_run_reg <= 1'b0;
          integration_start_o <= 1'b1;
        end else begin
          exp_cnt_reg <= exp_cnt_reg + 32'h1;
        end
      end
    end
  end

  // A trigger during a running strobe is ignored
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stb_state_reg <= STB_IDLE;
      stb_cnt_reg <= '0;
    end else begin
      case (stb_state_reg)
        STB_IDLE: begin
          stb_cnt_reg <= '0;
          if (tim_trig) stb_state_reg <= STB_DELAY;
        end
        STB_DELAY: begin
          if (stb_cnt_reg >= stb_dly_cyc) begin
            stb_state_reg <= STB_ON;
            stb_cnt_reg <= '0;
          end else begin
            stb_cnt_reg <= stb_cnt_reg + 32'h1;
          end
        end
        STB_ON: begin
          if (stb_cnt_reg + 32'h1 >= stb_dur_cyc) begin
            stb_state_reg <= STB_IDLE;
          end
          stb_cnt_reg <= stb_cnt_reg + 32'h1;
        end
        default: stb_state_reg <= STB_IDLE;
      endcase
    end
  end

  // Sequencer
  ssp_seq_state_t sq_state_reg;
  logic sq_prev_reg, sq_trig, us_tick, int_end, last_int;
  logic [3:0] idx_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [US_W-1:0] us_reg, dur_eff;
  logic [31:0] pwm_cnt_reg, pwm_period;
  logic [4:0] count_eff;
  logic sq_exp, sq_stb;
  logic [PWM_NUM-1:0] pwm_on;

  assign sq_trig = ctrl_reg[CTRL_SEQ_SW] ? seq_go_reg :
    (sequence_hw_trigger_i & ~sq_prev_reg);
  assign us_tick = (pre_reg == PRE_LAST);
  // A zero duration runs as one microsecond
  assign dur_eff = (seq_mem_reg[idx_reg][SF_DUR][US_W-1:0] == '0) ? US_W'(1) :
    seq_mem_reg[idx_reg][SF_DUR][US_W-1:0];
  assign count_eff = (seq_count_reg == '0) ? 5'h01 :
    ((32'(seq_count_reg) > NUM_INT) ? 5'(NUM_INT) : seq_count_reg);
  assign int_end = us_tick && ({1'b0, us_reg} + 1'b1 >= {1'b0, dur_eff});
  assign last_int = ({1'b0, idx_reg} + 1'b1 >= count_eff);
  assign pwm_period = seq_mem_reg[idx_reg][SF_PWM_PERIOD];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sq_prev_reg <= 1'b0;
    end else begin
      sq_prev_reg <= sequence_hw_trigger_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sq_state_reg <= SQ_IDLE;
      idx_reg <= '0;
      pre_reg <= '0;
      us_reg <= '0;
    end else begin
      case (sq_state_reg)
        SQ_IDLE: begin
          idx_reg <= '0;
          pre_reg <= '0;
          us_reg <= '0;
          if (sq_trig) sq_state_reg <= SQ_RUN;
        end
        SQ_RUN: begin
          if (int_end) begin
            pre_reg <= '0;
            us_reg <= '0;
            if (last_int) begin
              sq_state_reg <= SQ_IDLE;
            end else begin
              idx_reg <= idx_reg + 4'h1;
            end
          end else if (us_tick) begin
            pre_reg <= '0;
            us_reg <= us_reg + 1'b1;
          end else begin
            pre_reg <= pre_reg + 1'b1;
          end
        end
        default: sq_state_reg <= SQ_IDLE;
      endcase
    end
  end

  // PWM phase restarts at every interval so each starts clean
  always_ff @(posedge clk_i) begin
    if (reset_i || sq_state_reg != SQ_RUN || int_end) begin
      pwm_cnt_reg <= '0;
    end else if (pwm_cnt_reg + 32'h1 >= pwm_period) begin
      pwm_cnt_reg <= '0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 32'h1;
    end
  end

  assign sq_exp = (sq_state_reg == SQ_RUN) &&
    (32'(us_reg) >= seq_mem_reg[idx_reg][SF_EXP_START]) &&
    (32'(us_reg) < seq_mem_reg[idx_reg][SF_EXP_STOP]);
  assign sq_stb = (sq_state_reg == SQ_RUN) &&
    (32'(us_reg) >= seq_mem_reg[idx_reg][SF_STB_START]) &&
    (32'(us_reg) < seq_mem_reg[idx_reg][SF_STB_STOP]);

  // Compare in percent scale; products are 40 bits so nothing wraps
  always_comb begin
    logic [DUTY_W-1:0] duty;
    duty = '0;
    for (int c = 0; c < PWM_NUM; c++) begin
      duty = seq_mem_reg[idx_reg][32'(SF_DUTY0) + c][DUTY_W-1:0];
      if (sq_state_reg != SQ_RUN || duty == '0) begin
        pwm_on[c] = 1'b0;
      end else if (duty >= DUTY_FULL) begin
        pwm_on[c] = 1'b1;
      end else begin
        pwm_on[c] = (40'(pwm_cnt_reg) * PCT40) < (40'(duty) * 40'(pwm_period));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strobe_o <= 1'b0;
      exposure_o <= 1'b0;
      seq_active_o <= 1'b0;
      seq_pulse_o <= 1'b0;
      pwm_o <= '0;
    end else begin
      strobe_o <= ((stb_state_reg == STB_ON) | sq_stb) ^ ctrl_reg[CTRL_STB_LOW];
      exposure_o <= sq_exp;
      seq_active_o <= (sq_state_reg == SQ_RUN);
      // First cycle of every interval, so the pulse lines up with active
      seq_pulse_o <= (sq_state_reg == SQ_RUN) && (pre_reg == '0) &&
        (us_reg == '0);
      pwm_o <= pwm_on;
    end
  end

  // Read path
  always_comb begin
    rdata_next = '0;
    if (addr_i == ADDR_CTRL) begin
      rdata_next[2:0] = ctrl_reg;
    end else if (addr_i == ADDR_EXP_DELAY) begin
      rdata_next[US_W-1:0] = exp_delay_reg;
    end else if (addr_i == ADDR_STB_DELAY) begin
      rdata_next[US_W-1:0] = stb_delay_reg;
    end else if (addr_i == ADDR_STB_DUR) begin
      rdata_next[US_W-1:0] = stb_dur_reg;
    end else if (addr_i == ADDR_SEQ_COUNT) begin
      rdata_next[4:0] = seq_count_reg;
    end else if (addr_i == ADDR_STATUS) begin
      rdata_next[ST_PG +: NUM_PG] = pg_busy;
      rdata_next[ST_SEQ_ACT] = (sq_state_reg == SQ_RUN);
      rdata_next[ST_STB_ON] = (stb_state_reg == STB_ON);
      rdata_next[ST_IDX +: 4] = idx_reg;
    end else if (is_pg && 32'(pg_sel) < NUM_PG) begin
      if (pg_fld == PG_REG_CFG) begin
        rdata_next[2:0] = pg_cfg_reg[pg_sel];
      end else if (pg_fld == PG_REG_PRE) begin
        rdata_next = pg_pre_reg[pg_sel];
      end else if (pg_fld == PG_REG_POST) begin
        rdata_next = pg_post_reg[pg_sel];
      end else begin
        rdata_next[LOOP_W-1:0] = pg_loops_reg[pg_sel];
      end
    end else if (is_seq && 32'(sq_fld) < SEQ_FIELDS) begin
      rdata_next = seq_mem_reg[sq_sel][sq_fld];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i || !rd_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
endmodule

// ==== core/ssp_pkg.sv ====
package ssp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STB_MIN_US = 1;
  localparam int unsigned STB_MAX_US = 1000000;
  localparam int unsigned PCT_FULL = 100;

  localparam int unsigned PG_NUM = 4;
  localparam int unsigned PWM_NUM = 4;
  localparam int unsigned SEQ_MAX = 16;
  localparam int unsigned SEQ_FIELDS = 10;
  localparam int unsigned US_W = 20;
  localparam int unsigned DUTY_W = 7;
  localparam int unsigned LOOP_W = 16;
  localparam int unsigned PRE_W = 5;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_EXP_DELAY = 12'h004;
  localparam logic [11:0] ADDR_STB_DELAY = 12'h008;
  localparam logic [11:0] ADDR_STB_DUR = 12'h00C;
  localparam logic [11:0] ADDR_SEQ_COUNT = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [5:0] ADDR_PG_PAGE = 6'h01;
  localparam logic [1:0] ADDR_SEQ_PAGE = 2'h1;

  localparam logic [1:0] PG_REG_CFG = 2'h0;
  localparam logic [1:0] PG_REG_PRE = 2'h1;
  localparam logic [1:0] PG_REG_POST = 2'h2;
  localparam logic [1:0] PG_REG_LOOPS = 2'h3;

  localparam logic [3:0] SF_DUR = 4'h0;
  localparam logic [3:0] SF_EXP_START = 4'h1;
  localparam logic [3:0] SF_EXP_STOP = 4'h2;
  localparam logic [3:0] SF_STB_START = 4'h3;
  localparam logic [3:0] SF_STB_STOP = 4'h4;
  localparam logic [3:0] SF_PWM_PERIOD = 4'h5;
  localparam logic [3:0] SF_DUTY0 = 4'h6;

  localparam int unsigned CTRL_STB_LOW = 0;
  localparam int unsigned CTRL_TIM_SW = 1;
  localparam int unsigned CTRL_SEQ_SW = 2;
  localparam int unsigned CTRL_TIM_GO = 8;
  localparam int unsigned CTRL_SEQ_GO = 9;
  localparam int unsigned CTRL_PG_GO = 12;

  localparam int unsigned PG_CFG_SW = 0;
  localparam int unsigned PG_CFG_LEVEL = 1;
  localparam int unsigned PG_CFG_HIGH = 2;

  localparam int unsigned ST_PG = 0;
  localparam int unsigned ST_SEQ_ACT = 4;
  localparam int unsigned ST_STB_ON = 5;
  localparam int unsigned ST_IDX = 8;

  localparam logic [4:0] SEQ_COUNT_RST = 5'h01;

  typedef enum logic [1:0] {PG_IDLE, PG_PRE, PG_POST} ssp_pg_state_t;
  typedef enum logic [1:0] {STB_IDLE, STB_DELAY, STB_ON} ssp_stb_state_t;
  typedef enum logic {SQ_IDLE, SQ_RUN} ssp_seq_state_t;
endpackage

// ==== core/ssp_pulse_gen.sv ====
`timescale 1ns/1ps
module ssp_pulse_gen #(
  parameter int unsigned DUR_W = 32,
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hw_trig_i,
  input wire logic sw_trig_i,
  input wire logic use_sw_i,
  input wire logic level_mode_i,
  input wire logic start_high_i,
  input wire logic [DUR_W-1:0] pre_i,
  input wire logic [DUR_W-1:0] post_i,
  input wire logic [CNT_W-1:0] loops_i,
  output logic pulse_o,
  output logic busy_o
);
  import ssp_pkg::*;

  ssp_pg_state_t state_reg, state_next;
  logic hw_prev_reg;
  logic [DUR_W-1:0] cnt_reg;
  logic [CNT_W-1:0] loop_reg;
  logic trig, pre_done, post_done, last_loop;

  // Source and edge/level choice
  assign trig = use_sw_i ? sw_trig_i :
    (level_mode_i ? hw_trig_i : (hw_trig_i & ~hw_prev_reg));
  // Zero durations and zero loops behave as one
  assign pre_done = ({1'b0, cnt_reg} + 1'b1) >= {1'b0, pre_i};
  assign post_done = ({1'b0, cnt_reg} + 1'b1) >= {1'b0, post_i};
  assign last_loop = ({1'b0, loop_reg} + 1'b1) >= {1'b0, loops_i};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PG_IDLE: if (trig) state_next = PG_PRE;
      PG_PRE: if (pre_done) state_next = PG_POST;
      PG_POST: if (post_done) state_next = last_loop ? PG_IDLE : PG_PRE;
      default: state_next = PG_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= PG_IDLE;
      hw_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hw_prev_reg <= hw_trig_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (state_reg != PG_IDLE) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || state_reg == PG_IDLE) begin
      loop_reg <= '0;
    end else if (state_reg == PG_POST && post_done) begin
      loop_reg <= loop_reg + 1'b1;
    end
  end

  // Pre phase takes the start level, post phase and idle the opposite
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pulse_o <= 1'b1;
    end else begin
      pulse_o <= (state_next == PG_PRE) ? start_high_i : ~start_high_i;
    end
  end

  assign busy_o = (state_reg != PG_IDLE);
endmodule

// ==== tb/ssp_core_props.sv ====
`timescale 1ns/1ps
module ssp_core_props #(
  parameter int unsigned NUM_PG = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic sequence_hw_trigger_i,
  input wire logic [NUM_PG-1:0] pulse_o,
  input wire logic integration_start_o,
  input wire logic exposure_o,
  input wire logic seq_active_o,
  input wire logic seq_pulse_o,
  input wire logic [3:0] pwm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Read data only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside answer cycle");
  // Eight quiet cycles follow each interval start pulse
  a_seq_pulse_gap: assert property (seq_pulse_o |=> (!seq_pulse_o) [*8])
    else $error("interval start pulses too close");
  a_pulse_in_run: assert property (seq_pulse_o |-> seq_active_o)
    else $error("interval pulse while idle");
  a_seq_starts: assert property ($rose(sequence_hw_trigger_i) && !seq_active_o |-> ##2 seq_active_o)
    else $error("sequencer did not start");
  a_first_interval: assert property ($rose(seq_active_o) |-> seq_pulse_o)
    else $error("run began without interval pulse");
  a_integ_one_cycle: assert property (integration_start_o |=> !integration_start_o)
    else $error("integration start longer than a cycle");
  a_pwm_in_run: assert property (pwm_o != 4'h0 |-> seq_active_o)
    else $error("light channel on while idle");
  a_idle_quiet: assert property (!seq_active_o && !$past(seq_active_o) |-> !exposure_o)
    else $error("exposure while idle");
endmodule

bind ssp_core ssp_core_props #(.NUM_PG(NUM_PG)) i_ssp_core_props (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .sequence_hw_trigger_i(sequence_hw_trigger_i),
  .pulse_o(pulse_o),
  .integration_start_o(integration_start_o),
  .exposure_o(exposure_o),
  .seq_active_o(seq_active_o),
  .seq_pulse_o(seq_pulse_o),
  .pwm_o(pwm_o)
);

// ==== tb/ssp_trig_src.sv ====
`timescale 1ns/1ps
// Trigger lines from the routing matrix: bit 0 timing, 1 sequencer, 5:2 pulse generators
module ssp_trig_src #(
  parameter int unsigned HOLD = 20
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [5:0] fire_i,
  output logic [5:0] trig_o
);
  logic [7:0] cnt_reg [6];
  // Each line held high a fixed time so level mode sees a real level
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 6; k++) begin
      if (reset_i) begin
        cnt_reg[k] <= 8'h00;
      end else if (fire_i[k]) begin
        cnt_reg[k] <= 8'(HOLD);
      end else if (cnt_reg[k] != 8'h00) begin
        cnt_reg[k] <= cnt_reg[k] - 8'h01;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      trig_o[k] = (cnt_reg[k] != 8'h00);
    end
  end
endmodule

// ==== tb/ssp_core_bench.sv ====
`timescale 1ns/1ps
module ssp_core_bench;
  import ssp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [5:0] fire = 6'h00;
  logic [5:0] trig;
  logic [3:0] pulse_o;
  logic integration_start_o;
  logic strobe_o;
  logic exposure_o;
  logic seq_active_o;
  logic seq_pulse_o;
  logic [3:0] pwm_o;
  int errors = 0;
  int n_tests = 0;

  ssp_core i_ssp_core (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trigger_i(trig[0]),
    .sequence_hw_trigger_i(trig[1]), .pg_hw_trigger_i(trig[5:2]), .pulse_o(pulse_o),
    .integration_start_o(integration_start_o), .strobe_o(strobe_o), .exposure_o(exposure_o),
    .seq_active_o(seq_active_o), .seq_pulse_o(seq_pulse_o), .pwm_o(pwm_o));
  ssp_trig_src i_ssp_trig_src (.clk_i(clk_i), .reset_i(reset_i), .fire_i(fire), .trig_o(trig));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic test_done;
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", exp, rdata_o);
  endtask

  task automatic shoot(input logic [5:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 6'h00;
  endtask

  function automatic logic sig(input int s);
    case (s)
      4: return strobe_o;
      5: return integration_start_o;
      6: return trig[0];
      7: return seq_active_o;
      default: return pulse_o[s];
    endcase
  endfunction

  // Bounded wait; a hang here ends the run
  task automatic wait_lvl(input int s, input logic lvl);
    int n;
    n = 0;
    @(negedge clk_i);
    while (sig(s) !== lvl && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (sig(s) !== lvl) begin
      errors++;
      test_done();
    end
  endtask

  // Run length capped at 100, so a level that never changes reads as 100
  task automatic run_len(input int s, input logic lvl, output int n);
    n = 0;
    while (sig(s) === lvl && n < 100) begin
      n++;
      @(negedge clk_i);
    end
  endtask

  task automatic t_reset;
    chk("pulse idle", 32'hF, 32'(pulse_o));
    chk("strobe idle", 32'h0, 32'(strobe_o));
    rd_chk(ADDR_STB_DUR, 32'h1);
    rd_chk(ADDR_SEQ_COUNT, 32'h1);
    rd_chk(ADDR_EXP_DELAY, 32'h0);
    rd_chk(12'h7F0, 32'h0);
  endtask

  task automatic t_timing;
    int n;
    wr(ADDR_EXP_DELAY, 32'h1);
    wr(ADDR_STB_DELAY, 32'h1);
    wr(ADDR_STB_DUR, 32'h2);
    shoot(6'h01);
    wait_lvl(6, 1'b1);
    run_len(5, 1'b0, n);
    chk("exposure delay", 32'(2 + US_CYCLES), 32'(n));
    run_len(4, 1'b0, n);
    chk("strobe delay", 32'h1, 32'(n));
    run_len(4, 1'b1, n);
    chk("strobe width", 32'(2 * US_CYCLES), 32'(n));
    // Software trigger of the timing path must land like the line does
    wr(ADDR_CTRL, 32'h102);
    @(negedge clk_i);
    run_len(5, 1'b0, n);
    chk("sw exposure delay", 32'(2 + US_CYCLES), 32'(n));
    run_len(4, 1'b0, n);
    chk("sw strobe delay", 32'h1, 32'(n));
    run_len(4, 1'b1, n);
    chk("sw strobe width", 32'(2 * US_CYCLES), 32'(n));
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    @(negedge clk_i);
    chk("strobe active low idle", 32'h1, 32'(strobe_o));
    wr(ADDR_CTRL, 32'h0);
  endtask

  task automatic t_pg;
    int n;
    wr(12'h040, 32'h5);
    wr(12'h044, 32'h3);
    wr(12'h048, 32'h2);
    wr(12'h04C, 32'h2);
    wr(ADDR_CTRL, 32'h1000);
    wait_lvl(0, 1'b1);
    run_len(0, 1'b1, n);
    chk("pre", 32'h3, 32'(n));
    run_len(0, 1'b0, n);
    chk("post", 32'h2, 32'(n));
    run_len(0, 1'b1, n);
    chk("second pre", 32'h3, 32'(n));
    run_len(0, 1'b0, n);
    chk("after loops", 32'd100, 32'(n));
    wr(12'h054, 32'h4);
    shoot(6'h08);
    wait_lvl(1, 1'b0);
    run_len(1, 1'b0, n);
    chk("edge pre", 32'h4, 32'(n));
    run_len(1, 1'b1, n);
    chk("edge no retrigger", 32'd100, 32'(n));
    wr(12'h060, 32'h2);
    wr(12'h064, 32'h4);
    shoot(6'h10);
    wait_lvl(2, 1'b0);
    run_len(2, 1'b0, n);
    chk("level pre", 32'h4, 32'(n));
    wait_lvl(2, 1'b0);
  endtask

  task automatic t_seq;
    logic [31:0] cfg [20] = '{2, 0, 1, 1, 2, 10, 100, 0, 50, 30, 1, 0, 0, 0, 0, 10, 0, 100, 0, 0};
    int cyc;
    int pul;
    int ex;
    int sb;
    int n;
    int pw [4];
    cyc = 0;
    pul = 0;
    ex = 0;
    sb = 0;
    pw = '{0, 0, 0, 0};
    wr(ADDR_SEQ_COUNT, 32'h2);
    // Exposure windows kept inside each interval
    for (int k = 0; k < 20; k++) begin
      wr(12'h400 + 12'(64 * (k / 10)) + 12'(4 * (k % 10)), cfg[k]);
    end
    shoot(6'h02);
    wait_lvl(7, 1'b1);
    while (seq_active_o === 1'b1 && cyc < 500) begin
      cyc++;
      pul += int'(seq_pulse_o === 1'b1);
      ex += int'(exposure_o === 1'b1);
      sb += int'(strobe_o === 1'b1);
      for (int c = 0; c < 4; c++) begin
        pw[c] += int'(pwm_o[c] === 1'b1);
      end
      @(negedge clk_i);
    end
    chk("run length", 32'(3 * US_CYCLES), 32'(cyc));
    chk("interval pulses", 32'h2, 32'(pul));
    chk("exposure", 32'(US_CYCLES), 32'(ex));
    chk("seq strobe", 32'(US_CYCLES), 32'(sb));
    chk("pwm0", 32'(2 * US_CYCLES), 32'(pw[0]));
    chk("pwm1", 32'(US_CYCLES), 32'(pw[1]));
    chk("pwm2", 32'(US_CYCLES), 32'(pw[2]));
    chk("pwm3", 32'd15, 32'(pw[3]));
    chk("lights after run", 32'h0, 32'(pwm_o));
    chk("exposure after run", 32'h0, 32'(exposure_o));
    // Software start of the sequencer runs the same intervals
    wr(ADDR_CTRL, 32'h204);
    wait_lvl(7, 1'b1);
    run_len(7, 1'b1, n);
    chk("sw run length", 32'(3 * US_CYCLES), 32'(n));
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    t_reset();
    t_timing();
    t_pg();
    t_seq();
    test_done();
  end
endmodule
